// ---- logic/spc_map.svh ----
// register offsets, field positions, lock layout, command codes and timing counts
// assumes a 40 MHz core clock and a x16 flash bus
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_CLK_NS 25
// software registers (byte offsets)
`define SPC_REG_CTRL 8'h00
`define SPC_REG_ADDR 8'h04
`define SPC_REG_DATA 8'h08
`define SPC_REG_STAT 8'h0c
`define SPC_REG_PW0 8'h10
`define SPC_REG_PW3 8'h1c
// control fields
`define SPC_CTRL_OP_LSB 0
`define SPC_CTRL_GO_BIT 8
`define SPC_CTRL_FINAL_BIT 9
`define SPC_CTRL_HOLD_BIT 10
// status fields
`define SPC_STAT_BUSY_BIT 0
`define SPC_STAT_DONE_BIT 1
`define SPC_STAT_FAIL_BIT 2
`define SPC_STAT_REFUSED_BIT 3
`define SPC_STAT_DATA_LSB 16
// lock register layout
`define SPC_LK_SSR0_BIT 0
`define SPC_LK_PERS_BIT 1
`define SPC_LK_PASS_BIT 2
`define SPC_LK_SSR1_BIT 6
`define SPC_LK_USED_MASK 16'h0047
// command codes written as the first word of each sequence (arbitrary values)
`define SPC_CODE_FREEZE 16'h00a1
`define SPC_CODE_PG_PROG 16'h00a2
`define SPC_CODE_PG_ERASE 16'h00a3
`define SPC_CODE_DG_SET 16'h00a4
`define SPC_CODE_DG_CLEAR 16'h00a5
`define SPC_CODE_LOCK_PROG 16'h00a6
`define SPC_CODE_PW_PROG 16'h00a7
`define SPC_CODE_UNLOCK 16'h00a8
// bus timing, least times rounded up
`define SPC_T_WE_NS 50
`define SPC_T_WH_NS 30
`define SPC_T_RD_NS 100
`define SPC_WE_CYC ((`SPC_T_WE_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_WH_CYC ((`SPC_T_WH_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_RD_CYC ((`SPC_T_RD_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
// unlock spacing: 100 us plus the 20 us tolerance
`define SPC_T_GAP_US 120
`define SPC_GAP_CYC ((`SPC_T_GAP_US * 1000 + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_T_POLL_US 5000
`define SPC_POLL_CYC ((`SPC_T_POLL_US * 1000) / `SPC_CLK_NS)
`endif

// ---- logic/spc_pkg.sv ----
// types shared by the sector protection host controller
// assumes spc_map.svh for all numeric constants
package spc_pkg;
  typedef enum logic [3:0] {
    SPC_OP_NONE, SPC_OP_FREEZE, SPC_OP_PG_PROG, SPC_OP_PG_ERASE, SPC_OP_DG_SET,
    SPC_OP_DG_CLEAR, SPC_OP_LOCK_PROG, SPC_OP_PW_PROG, SPC_OP_UNLOCK
  } spc_op_t;
  typedef enum logic [2:0] {
    SPC_ST_IDLE, SPC_ST_LOAD, SPC_ST_WR_LO, SPC_ST_WR_HI, SPC_ST_RD_LO, SPC_ST_RD_HI
  } spc_state_t;
endpackage

// ---- logic/spc_pw_mem.sv ----
// small password word store, read data registered
// assumes one clock, write and read ports independent
`timescale 1ns/1ps
module spc_pw_mem #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata_q
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// ---- logic/spc_host.sv ----
// host controller driving flash sector protection commands over the x16 bus
// assumes an ahb-lite master for software, a synchronous flash bus view
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_host import spc_pkg::*; #(
  parameter int ADDR_W = 26,
  parameter int GAP_CYC = `SPC_GAP_CYC,
  parameter int POLL_CYC = `SPC_POLL_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_reset_n,
  input wire logic ready_busy_output
);
  localparam logic [7:0] WE_CYC = 8'(`SPC_WE_CYC);
  localparam logic [7:0] WH_CYC = 8'(`SPC_WH_CYC);
  localparam logic [7:0] RD_CYC = 8'(`SPC_RD_CYC);

  spc_state_t state_q, state_d;
  spc_op_t op_q, op_d;
  logic [2:0] step_q, step_d;
  logic [7:0] cnt_q, cnt_d;
  logic [31:0] poll_q, poll_d, gap_q, gap_d;
  logic [15:0] rd1_q, rd1_d, last_q, last_d;
  logic rdv_q, rdv_d, done_q, done_d, fail_q, fail_d, ref_q, ref_d;
  logic final_q, final_d, hold_q, hold_d;
  logic [ADDR_W-1:0] areg_q, areg_d, fa_q, fa_d;
  logic [15:0] dreg_q, dreg_d, fd_q, fd_d;
  logic foe_q, foe_d, ce_q, ce_d, we_q, we_d, oe_q, oe_d;
  logic ap_wr_q, ap_rd;
  logic [7:0] ap_addr_q;
  logic [31:0] hrdata_q, rmux;
  logic wr_ctrl, go, refuse, clr_stat, pw_we, lock_both;
  spc_op_t go_op;
  logic [15:0] pw_rdata;
  logic [1:0] pw_raddr;

  function automatic logic [15:0] op_code(input spc_op_t op);
    case (op)
      SPC_OP_FREEZE: op_code = `SPC_CODE_FREEZE;
      SPC_OP_PG_PROG: op_code = `SPC_CODE_PG_PROG;
      SPC_OP_PG_ERASE: op_code = `SPC_CODE_PG_ERASE;
      SPC_OP_DG_SET: op_code = `SPC_CODE_DG_SET;
      SPC_OP_DG_CLEAR: op_code = `SPC_CODE_DG_CLEAR;
      SPC_OP_LOCK_PROG: op_code = `SPC_CODE_LOCK_PROG;
      SPC_OP_PW_PROG: op_code = `SPC_CODE_PW_PROG;
      SPC_OP_UNLOCK: op_code = `SPC_CODE_UNLOCK;
      default: op_code = 16'h0000;
    endcase
  endfunction

  // index of the last write of each sequence
  function automatic logic [2:0] last_step(input spc_op_t op);
    case (op)
      SPC_OP_LOCK_PROG, SPC_OP_PW_PROG: last_step = 3'h1;
      SPC_OP_UNLOCK: last_step = 3'h4;
      default: last_step = 3'h0;
    endcase
  endfunction

  // ahb-lite slave, zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign ap_rd = hsel && htrans[1] && hready && !hwrite;
  assign wr_ctrl = ap_wr_q && ap_addr_q == `SPC_REG_CTRL;
  assign go = wr_ctrl && hwdata[`SPC_CTRL_GO_BIT];
  assign go_op = spc_op_t'(hwdata[`SPC_CTRL_OP_LSB +: 4]);
  assign clr_stat = ap_wr_q && ap_addr_q == `SPC_REG_STAT;
  assign pw_we = ap_wr_q && ap_addr_q >= `SPC_REG_PW0 && ap_addr_q <= `SPC_REG_PW3;
  assign lock_both = !dreg_q[`SPC_LK_PERS_BIT] && !dreg_q[`SPC_LK_PASS_BIT];
  assign refuse = state_q != SPC_ST_IDLE || go_op == SPC_OP_NONE || go_op > SPC_OP_UNLOCK
    || (go_op == SPC_OP_FREEZE && !final_q) || (go_op == SPC_OP_UNLOCK && gap_q != 32'h0)
    || (go_op == SPC_OP_LOCK_PROG && lock_both);
  assign pw_raddr = step_d[1:0] - 2'h1;

  always_comb
  begin
    rmux = 32'h0;
    case (haddr[7:0])
      `SPC_REG_CTRL: rmux = {21'h0, hold_q, final_q, 5'h0, op_q};
      `SPC_REG_ADDR: rmux = 32'(areg_q);
      `SPC_REG_DATA: rmux = {16'h0, dreg_q};
      `SPC_REG_STAT: rmux = {last_q, 12'h0, ref_q, fail_q, done_q, state_q != SPC_ST_IDLE};
      default: rmux = 32'h0;
    endcase
  end

  spc_pw_mem #(.W(16), .DEPTH(4)) u_pw (
    .core_clk(core_clk),
    .we(pw_we),
    .waddr(ap_addr_q[3:2]),
    .wdata(hwdata[15:0]),
    .raddr(pw_raddr),
    .rdata_q(pw_rdata)
  );

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    step_d = step_q;
    cnt_d = cnt_q;
    poll_d = poll_q;
    gap_d = (gap_q != 32'h0) ? gap_q - 32'h1 : gap_q;
    rd1_d = rd1_q;
    last_d = last_q;
    rdv_d = rdv_q;
    done_d = done_q & ~(clr_stat & hwdata[`SPC_STAT_DONE_BIT]);
    fail_d = fail_q & ~(clr_stat & hwdata[`SPC_STAT_FAIL_BIT]);
    ref_d = ref_q & ~(clr_stat & hwdata[`SPC_STAT_REFUSED_BIT]);
    final_d = wr_ctrl ? hwdata[`SPC_CTRL_FINAL_BIT] : final_q;
    hold_d = wr_ctrl ? hwdata[`SPC_CTRL_HOLD_BIT] : hold_q;
    areg_d = (ap_wr_q && ap_addr_q == `SPC_REG_ADDR) ? hwdata[ADDR_W-1:0] : areg_q;
    dreg_d = (ap_wr_q && ap_addr_q == `SPC_REG_DATA) ? hwdata[15:0] : dreg_q;
    fa_d = fa_q;
    fd_d = fd_q;
    foe_d = foe_q;
    ce_d = ce_q;
    we_d = we_q;
    oe_d = oe_q;
    if (go && refuse)
    begin
      ref_d = 1'b1;
    end
    case (state_q)
      SPC_ST_IDLE:
      begin
        if (go && !refuse)
        begin
          op_d = go_op;
          step_d = 3'h0;
          done_d = 1'b0;
          fail_d = 1'b0;
          state_d = SPC_ST_LOAD;
          if (go_op == SPC_OP_UNLOCK)
          begin
            gap_d = 32'(GAP_CYC);
          end
        end
      end
      SPC_ST_LOAD:
      begin
        fa_d = areg_q;
        if (step_q == 3'h0)
        begin
          fd_d = op_code(op_q);
        end
        else if (op_q == SPC_OP_UNLOCK)
        begin
          fa_d = {areg_q[ADDR_W-1:2], 2'(step_q - 3'h1)};
          fd_d = pw_rdata;
        end
        else if (op_q == SPC_OP_LOCK_PROG)
        begin
          fd_d = dreg_q | ~`SPC_LK_USED_MASK;
        end
        else
        begin
          fd_d = dreg_q;
        end
        foe_d = 1'b1;
        ce_d = 1'b0;
        we_d = 1'b0;
        cnt_d = WE_CYC - 8'h1;
        state_d = SPC_ST_WR_LO;
      end
      SPC_ST_WR_LO:
      begin
        cnt_d = cnt_q - 8'h1;
        if (cnt_q == 8'h0)
        begin
          we_d = 1'b1;
          ce_d = 1'b1;
          cnt_d = WH_CYC - 8'h1;
          state_d = SPC_ST_WR_HI;
        end
      end
      SPC_ST_WR_HI:
      begin
        cnt_d = cnt_q - 8'h1;
        if (cnt_q == 8'h0)
        begin
          if (step_q == last_step(op_q))
          begin
            // poll toggle status before another command
            foe_d = 1'b0;
            rdv_d = 1'b0;
            poll_d = 32'(POLL_CYC);
            ce_d = 1'b0;
            oe_d = 1'b0;
            cnt_d = RD_CYC - 8'h1;
            state_d = SPC_ST_RD_LO;
          end
          else
          begin
            step_d = step_q + 3'h1;
            state_d = SPC_ST_LOAD;
          end
        end
      end
      SPC_ST_RD_LO, SPC_ST_RD_HI:
      begin
        cnt_d = cnt_q - 8'h1;
        poll_d = poll_q - 32'h1;
        if (poll_q == 32'h0)
        begin
          // still toggling: failed unlock or timed-out guard command
          fail_d = 1'b1;
          done_d = 1'b1;
          ce_d = 1'b1;
          oe_d = 1'b1;
          state_d = SPC_ST_IDLE;
        end
        else if (cnt_q == 8'h0 && state_q == SPC_ST_RD_LO)
        begin
          ce_d = 1'b1;
          oe_d = 1'b1;
          rd1_d = fl_dq_i;
          rdv_d = 1'b1;
          cnt_d = WH_CYC - 8'h1;
          state_d = SPC_ST_RD_HI;
          if (rdv_q && fl_dq_i[6] == rd1_q[6] && ready_busy_output)
          begin
            last_d = fl_dq_i;
            done_d = 1'b1;
            state_d = SPC_ST_IDLE;
          end
        end
        else if (cnt_q == 8'h0)
        begin
          ce_d = 1'b0;
          oe_d = 1'b0;
          cnt_d = RD_CYC - 8'h1;
          state_d = SPC_ST_RD_LO;
        end
      end
      default: state_d = SPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= SPC_ST_IDLE;
      op_q <= SPC_OP_NONE;
      step_q <= 3'h0;
      cnt_q <= 8'h0;
      poll_q <= 32'h0;
      gap_q <= 32'h0;
      rd1_q <= 16'h0;
      last_q <= 16'h0;
      rdv_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      ref_q <= 1'b0;
      final_q <= 1'b0;
      hold_q <= 1'b0;
      areg_q <= '0;
      dreg_q <= 16'hffff;
      fa_q <= '0;
      fd_q <= 16'h0;
      foe_q <= 1'b0;
      ce_q <= 1'b1;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h0;
      hrdata_q <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      poll_q <= poll_d;
      gap_q <= gap_d;
      rd1_q <= rd1_d;
      last_q <= last_d;
      rdv_q <= rdv_d;
      done_q <= done_d;
      fail_q <= fail_d;
      ref_q <= ref_d;
      final_q <= final_d;
      hold_q <= hold_d;
      areg_q <= areg_d;
      dreg_q <= dreg_d;
      fa_q <= fa_d;
      fd_q <= fd_d;
      foe_q <= foe_d;
      ce_q <= ce_d;
      we_q <= we_d;
      oe_q <= oe_d;
      ap_wr_q <= hsel && htrans[1] && hready && hwrite;
      ap_addr_q <= (hsel && htrans[1] && hready) ? haddr[7:0] : ap_addr_q;
      hrdata_q <= ap_rd ? rmux : hrdata_q;
    end
  end

  assign fl_addr = fa_q;
  assign fl_dq_o = fd_q;
  assign fl_dq_oe = foe_q;
  assign fl_ce_n = ce_q;
  assign fl_we_n = we_q;
  assign fl_oe_n = oe_q;
  assign fl_reset_n = !hold_q;

  // helper: write strobes of the running sequence
  logic [3:0] wcnt_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wcnt_q <= 4'h0;
    end
    else
    begin
      wcnt_q <= (state_q == SPC_ST_IDLE) ? 4'h0 : wcnt_q + 4'($fell(we_q));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_freeze_needs_final: assert property (
    go && go_op == SPC_OP_FREEZE && !final_q |=> ref_q && state_q == SPC_ST_IDLE)
    else $error("freeze issued before guards were final");
  a_lock_reserved_ones: assert property (
    state_q == SPC_ST_WR_LO && op_q == SPC_OP_LOCK_PROG && step_q == 3'h1
    |-> (fl_dq_o | `SPC_LK_USED_MASK) == 16'hffff)
    else $error("lock write with a reserved bit low");
  a_lock_one_mode: assert property (
    go && go_op == SPC_OP_LOCK_PROG && lock_both |=> state_q == SPC_ST_IDLE)
    else $error("both mode lock bits sent together");
  a_unlock_four_words: assert property (
    op_q == SPC_OP_UNLOCK && state_q == SPC_ST_WR_HI && cnt_q == 8'h0
    && step_q == last_step(op_q) |-> wcnt_q == 4'h5)
    else $error("unlock polled without four password words");
  a_unlock_spacing: assert property (
    state_q == SPC_ST_IDLE && state_d == SPC_ST_LOAD && go_op == SPC_OP_UNLOCK
    |-> gap_q == 32'h0 ##1 gap_q == 32'(GAP_CYC))
    else $error("unlock issued inside the spacing window");
  a_poll_after_write: assert property (
    state_q == SPC_ST_WR_HI && cnt_q == 8'h0 && step_q == last_step(op_q)
    |=> state_q == SPC_ST_RD_LO && !fl_oe_n && !fl_dq_oe)
    else $error("sequence ended without status polling");
  a_we_pulse_width: assert property (
    $fell(fl_we_n) |-> !fl_we_n [*2] ##1 fl_we_n)
    else $error("write strobe width wrong");
  a_no_bus_fight: assert property (
    !(fl_dq_oe && !fl_oe_n))
    else $error("host drives data while flash output enabled");
  a_done_sticky: assert property (
    done_q && !clr_stat && !go |=> done_q)
    else $error("done flag lost without software clear");

  c_unlock_ok: cover property (op_q == SPC_OP_UNLOCK && $rose(done_q) && !fail_q);
  c_unlock_fail: cover property (op_q == SPC_OP_UNLOCK && $rose(fail_q));
  c_freeze_refused: cover property (go && go_op == SPC_OP_FREEZE && !final_q);
  c_lock_prog: cover property (op_q == SPC_OP_LOCK_PROG && $rose(done_q));
endmodule

// ---- test/spc_flash_model.sv ----
// behavioural flash device: guards, freeze bit, lock register, password store
// assumes host strobes change just after core_clk edges; sampled on the same clock
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_flash_model #(
  parameter int BUSY_CYC = 12,
  parameter int GAP_CYC = 100
) (
  input wire logic core_clk,
  input wire logic [25:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_dq_oe,
  output logic [15:0] fl_dq_i,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_reset_n,
  output logic ready_busy_output
);
  logic frz = 1'b1;
  logic [15:0] pg = '1;
  logic [15:0] dg = '1;
  logic [15:0] lock = 16'hfefe;
  logic [15:0] pw [4] = '{default: 16'hffff};
  logic [15:0] code = 0, d, word_q = 0, last_q = 0;
  logic [3:0] ok = 0, csec = 0;
  logic we_p = 1, ce_p = 1, oe_p = 1, tog = 0, hang = 0, rb_q = 1;
  int nwr = 0, need, busy = 0, gap = 0;
  wire [3:0] sec = fl_addr[19:16];
  wire [1:0] idx = fl_addr[1:0];
  // released bus shows the inverse of the last word
  assign fl_dq_i = fl_dq_oe ? fl_dq_o : (!fl_ce_n && !fl_oe_n) ? word_q : ~last_q;
  assign ready_busy_output = rb_q;
  always @(posedge core_clk)
  begin
    if (gap > 0) gap = gap - 1;
    if (busy > 0) busy = busy - 1;
    if (oe_p && !fl_oe_n && !fl_ce_n && (busy > 0 || hang)) tog = !tog;
    if (!we_p && fl_we_n && !ce_p && busy == 0 && !hang)
    begin
      if (nwr == 0)
      begin
        code = fl_dq_o;
        csec = sec;
        ok = 0;
      end
      else if (code == `SPC_CODE_UNLOCK && sec != csec) hang = 1'b1;
      else if (pw[idx] === fl_dq_o) ok[idx] = 1'b1;
      nwr = nwr + 1;
      need = (code == `SPC_CODE_UNLOCK) ? 5 :
        (code == `SPC_CODE_LOCK_PROG || code == `SPC_CODE_PW_PROG) ? 2 : 1;
      if (nwr >= need)
      begin
        nwr = 0;
        busy = BUSY_CYC;
        d = fl_dq_o;
        case (code)
          `SPC_CODE_FREEZE: frz = 1'b0;
          `SPC_CODE_PG_PROG: if (frz) pg[sec] = 1'b0; else hang = 1'b1;
          `SPC_CODE_PG_ERASE: if (frz) pg = '1; else hang = 1'b1;
          `SPC_CODE_DG_SET: dg[sec] = 1'b0;
          `SPC_CODE_DG_CLEAR: dg[sec] = 1'b1;
          `SPC_CODE_LOCK_PROG:
          begin
            if (!d[1] && !d[2]) hang = 1'b1;
            if (!lock[1]) d[2] = 1'b1;
            if (!lock[2]) d[1] = 1'b1;
            if (!hang) lock = lock & d;
          end
          `SPC_CODE_PW_PROG: if (lock[2]) pw[idx] = pw[idx] & d;
          `SPC_CODE_UNLOCK:
          begin
            if (gap == 0 && ok == 4'hf) frz = 1'b1; else hang = 1'b1;
            gap = GAP_CYC;
          end
          default: busy = 0;
        endcase
      end
    end
    if (!fl_reset_n)
    begin
      frz = lock[2];
      dg = '1;
      hang = 0;
      busy = 0;
      nwr = 0;
    end
    we_p = fl_we_n;
    ce_p = fl_ce_n;
    oe_p = fl_oe_n;
    if (!fl_ce_n && !fl_oe_n) last_q <= word_q;
    word_q <= (busy > 0 || hang) ? {8'h00, ~last_q[7], tog, 6'h00} :
      {lock[7:0], 4'h0, pg[sec] & dg[sec], dg[sec], pg[sec], frz};
    rb_q <= !(busy > 0 || hang);
  end
endmodule

// ---- test/spc_host_test.sv ----
// self-checking bench for spc_host with a behavioural flash on the far side
// assumes the design files and spc_flash_model.sv are compiled first
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_host_test import spc_pkg::*; ();
  logic core_clk = 0, rst_n = 0, hwrite = 0, dphase = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic hready, hresp, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, rb;
  logic [25:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic [71:0] notes [$];
  logic [71:0] nt;
  logic ex_frz = 1'b1;
  logic [15:0] ex_pg = '1, ex_dg = '1, ex_lock = 16'hfefe, ld;
  logic [15:0] pw [4];
  int fail_count = 0, comparisons = 0, cyc = 0;
  spc_host #(.GAP_CYC(150), .POLL_CYC(400)) spc_host_i (.core_clk(core_clk), .rst_n(rst_n),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n),
    .ready_busy_output(rb));
  spc_flash_model spc_flash_model_i (.core_clk(core_clk), .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n), .ready_busy_output(rb));
  always #12.5 core_clk = ~core_clk;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if ((g & m) !== (e & m))
    begin
      fail_count++;
      $display("MISMATCH reg %h expected %h seen %h", a, e & m, g & m);
    end
  endtask
  // result monitor: oldest note against each read data phase
  always @(posedge core_clk)
  begin
    if (dphase && hready === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt[63:32] != 0) cmp(nt[71:64], nt[63:32], nt[31:0], hrdata);
    end
    dphase <= htrans[1] && hready && !hwrite;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    output logic [31:0] q);
    notes.push_back({a, m, e});
    ahb(1'b0, a, 32'h0, q);
  endtask
  function automatic logic [15:0] sw(input logic [3:0] s);
    return {ex_lock[7:0], 4'h0, ex_pg[s] & ex_dg[s], ex_dg[s], ex_pg[s], ex_frz};
  endfunction
  // start an operation, wait for done or refusal, check status, and device state only when it succeeds
  task automatic op(input spc_op_t o, input logic fin, input logic [19:0] a,
    input logic [3:0] st);
    logic [31:0] q;
    int n;
    wr(`SPC_REG_ADDR, {12'h0, a});
    wr(`SPC_REG_CTRL, {22'h0, fin, 1'b0, 4'h0, o});
    wr(`SPC_REG_CTRL, {22'h0, fin, 1'b1, 4'h0, o});
    n = 0;
    do
    begin
      rd(`SPC_REG_STAT, 32'h0, 32'h0, q);
      n++;
    end
    while (q[1] !== 1'b1 && q[3] !== 1'b1 && n < 3000);
    rd(`SPC_REG_STAT, {(st == 4'h2) ? 16'hffff : 16'h0, 12'h0, st[3] ? 4'h8 : 4'hf},
      {sw(a[19:16]), 12'h0, st}, q);
    wr(`SPC_REG_STAT, 32'he);
  endtask
  task automatic probe(input logic [3:0] s);
    wr(`SPC_REG_DATA, 32'hffff);
    op(SPC_OP_PW_PROG, 1'b0, {s, 16'h0}, 4'h2);
  endtask
  task automatic hw_reset();
    wr(`SPC_REG_CTRL, 32'h400);
    repeat (4) @(posedge core_clk);
    wr(`SPC_REG_CTRL, 32'h0);
    ex_frz = ex_lock[2];
    ex_dg = '1;
  endtask
  initial
  begin
    logic [31:0] q;
    logic [3:0] s;
    void'($urandom(45485));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h40, '1, 32'h0, q);
    rd(`SPC_REG_STAT, 32'hf, 32'h0, q);
    s = 4'($urandom_range(15, 0));
    ex_dg[s] = 1'b0;
    op(SPC_OP_DG_SET, 1'b0, {s, 16'h0}, 4'h2);
    ex_pg[s] = 1'b0;
    op(SPC_OP_PG_PROG, 1'b0, {s, 16'h0}, 4'h2);
    ex_dg[s] = 1'b1;
    op(SPC_OP_DG_CLEAR, 1'b0, {s, 16'h0}, 4'h2);
    ex_pg = '1;
    op(SPC_OP_PG_ERASE, 1'b0, {s, 16'h0}, 4'h2);
    op(SPC_OP_FREEZE, 1'b0, {s, 16'h0}, 4'h8);
    ex_frz = 1'b0;
    op(SPC_OP_FREEZE, 1'b1, {s, 16'h0}, 4'h2);
    ex_dg[s] = 1'b0;
    op(SPC_OP_DG_SET, 1'b0, {s, 16'h0}, 4'h2);
    op(SPC_OP_PG_PROG, 1'b0, {s, 16'h0}, 4'h6);
    hw_reset();
    probe(s);
    wr(`SPC_REG_DATA, 32'hfff9);
    op(SPC_OP_LOCK_PROG, 1'b0, {s, 16'h0}, 4'h8);
    for (int i = 0; i < 4; i++)
    begin
      pw[i] = 16'($urandom());
      wr(`SPC_REG_DATA, {16'h0, pw[i]});
      op(SPC_OP_PW_PROG, 1'b0, {s, 14'h0, 2'(i)}, 4'h2);
      wr(`SPC_REG_PW0 + 8'(4 * i), {16'h0, pw[i]});
    end
    for (int i = 0; i < 3; i++)
    begin
      ld = (i == 0) ? 16'hfffb : (i == 1) ? 16'hfffd : 16'hffbf;
      if (i != 1) ex_lock = ex_lock & ld;
      wr(`SPC_REG_DATA, {16'h0, ld});
      op(SPC_OP_LOCK_PROG, 1'b0, {s, 16'h0}, 4'h2);
    end
    hw_reset();
    probe(s);
    wr(`SPC_REG_PW3, {16'h0, ~pw[3]});
    repeat (160) @(posedge core_clk);
    op(SPC_OP_UNLOCK, 1'b0, {s, 16'h0}, 4'h6);
    hw_reset();
    wr(`SPC_REG_PW3, {16'h0, pw[3]});
    repeat (160) @(posedge core_clk);
    ex_frz = 1'b1;
    op(SPC_OP_UNLOCK, 1'b0, {s, 16'h0}, 4'h2);
    op(SPC_OP_UNLOCK, 1'b0, {s, 16'h0}, 4'h8);
    ex_frz = 1'b0;
    op(SPC_OP_FREEZE, 1'b1, {s, 16'h0}, 4'h2);
    final_report();
  end
endmodule
